// ---- rtl/tgt_pkg.sv ----
// Constants and register map of the tone generator with duration timer
// How it works
// RL1 - Tone is an equal high/low square wave
// RL2 - Tone active while timer nonzero or forced
// RL3 - Force-on holds tone until cleared
// RL4 - Idle tone terminal driven constant low
// RL5 - Pin-float bit tristates the terminal at once
// RL6 - Select 0 silence, else divide 8..24
// RL7 - Timer runs and interrupts during silence
// RL8 - Every zero reached sets the interrupt flag
// RL9 - Writing period zero stops without interrupt
// RL10 - Single-shot counts down, stops at zero
// RL11 - Single-shot tone starts at next tick edge
// RL12 - Auto-reload reloads period at every zero
// RL13 - Clearing auto finishes run, then stops
// RL14 - Period zero in auto clears auto bit
// RL15 - Setting auto enables tone immediately
// RL16 - Mode bit zero single-shot, one auto
// RL17 - Tick select picks a prescaler tap
// RL18 - Run length is period times tick period
// RL19 - Bit 3 writes force-on, reads active flag
// RL20 - Software programs auto mode in order
// RL21 - Software keeps tick select stable while running
// RL22 - Reset clears every field to zero
// RL23 - Tick edges detected on the system clock
package tgt_pkg;
  localparam logic [2:0] TGT_ADDR_SEL    = 3'h0;
  localparam logic [2:0] TGT_ADDR_TIM    = 3'h1;
  localparam logic [2:0] TGT_ADDR_PER    = 3'h2;
  localparam logic [2:0] TGT_ADDR_IRQ    = 3'h3;
  localparam logic [2:0] TGT_ADDR_MASK   = 3'h4;
  localparam int         TGT_BIT_FLOAT   = 3;
  localparam int         TGT_BIT_FORCE   = 3;
  localparam int         TGT_BIT_AUTO    = 2;
  localparam logic [3:0] TGT_RST_NIBBLE  = 4'h0;
  localparam logic [4:0] TGT_DIV_RST     = 5'h00;
  localparam int         TGT_TAP_SEL0    = 3;
  localparam int         TGT_TAP_SEL1    = 5;
  localparam int         TGT_TAP_SEL2    = 7;
  localparam int         TGT_TAP_SEL3    = 1;
endpackage

// ---- rtl/tgt_top.sv ----
// Tone generator with 4-bit duration timer
`timescale 1ns/100ps
`default_nettype none
module tgt_top import tgt_pkg::*; #(
  parameter int CKW = 16
) (
  input  wire logic           mclk,
  input  wire logic           rst,
  input  wire logic [2:0]     addr,
  input  wire logic [3:0]     wdata,
  input  wire logic           wr,
  input  wire logic           rd,
  output logic      [3:0]     rdata,
  input  wire logic [CKW-1:0] presc_ck,
  output logic                tone_out,
  output logic                tone_oe,
  output logic                tone_timer_irq
);
  logic [3:0] sel_r, per_r, cnt_r;
  logic       force_r, auto_r, tsh_r, tsl_r;
  logic       run_r, pend_r, irqf_r, mask_r, tick_d_r, tick_s_r;
  logic [4:0] div_r;
  logic       sq_r;
  logic [3:0] rdata_r;

  // Half period of the square wave in system clocks
  function automatic logic [4:0] tgt_half(input logic [2:0] s);
    case (s)
      3'd1:    tgt_half = 5'h04;
      3'd2:    tgt_half = 5'h05;
      3'd3:    tgt_half = 5'h06;
      3'd4:    tgt_half = 5'h07;
      3'd5:    tgt_half = 5'h08;
      3'd6:    tgt_half = 5'h0A;
      3'd7:    tgt_half = 5'h0C;
      default: tgt_half = 5'h00;
    endcase
  endfunction

  wire w_sel = wr && addr == TGT_ADDR_SEL;
  wire w_tim = wr && addr == TGT_ADDR_TIM;
  wire w_per = wr && addr == TGT_ADDR_PER;
  wire w_irq = wr && addr == TGT_ADDR_IRQ;
  wire w_msk = wr && addr == TGT_ADDR_MASK;
  wire [2:0] tone_select = sel_r[2:0];
  wire [1:0] tsel = {tsh_r, tsl_r};
  wire tick_raw = (tsel == 2'b00) ? presc_ck[TGT_TAP_SEL0] :   // RL17
                  (tsel == 2'b01) ? presc_ck[TGT_TAP_SEL1] :
                  (tsel == 2'b10) ? presc_ck[TGT_TAP_SEL2] : presc_ck[TGT_TAP_SEL3];
  wire tick = tick_s_r && !tick_d_r;                              // RL23
  wire per_zero_wr = w_per && wdata == 4'h0;
  wire auto_set = w_tim && wdata[TGT_BIT_AUTO] && !auto_r;
  wire hit_zero = run_r && tick && cnt_r == 4'h1;                 // RL18
  wire tone_active = force_r || (run_r && cnt_r != 4'h0);         // RL2 RL3
  wire [4:0] half = tgt_half(tone_select);
  wire div_end = div_r + 5'h01 >= half;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_s_r <= 1'b0;
      tick_d_r <= 1'b0;
    end else begin
      tick_s_r <= tick_raw;
      tick_d_r <= tick_s_r;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin                                                // RL22
      sel_r   <= TGT_RST_NIBBLE;
      force_r <= 1'b0;
      tsh_r   <= 1'b0;
      tsl_r   <= 1'b0;
      mask_r  <= 1'b0;
    end else begin
      if (w_sel) sel_r <= wdata;
      if (w_tim) begin
        force_r <= wdata[TGT_BIT_FORCE];                          // RL19
        tsh_r   <= wdata[1];
        tsl_r   <= wdata[0];
      end
      if (w_msk) mask_r <= wdata[0];
    end
  end

  // Timer: pend waits for the next tick edge before a single-shot run starts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      per_r  <= TGT_RST_NIBBLE;
      cnt_r  <= TGT_RST_NIBBLE;
      auto_r <= 1'b0;
      run_r  <= 1'b0;
      pend_r <= 1'b0;
    end else if (per_zero_wr) begin                               // RL9 RL14
      per_r  <= 4'h0;
      cnt_r  <= 4'h0;
      run_r  <= 1'b0;
      pend_r <= 1'b0;
      auto_r <= 1'b0;
    end else if (w_per) begin
      per_r  <= wdata;
      cnt_r  <= wdata;
      pend_r <= !auto_r;                                          // RL11
    end else begin
      if (w_tim) auto_r <= wdata[TGT_BIT_AUTO];                   // RL16
      if (auto_set && per_r != 4'h0) begin                        // RL15
        run_r  <= 1'b1;
        pend_r <= 1'b0;
        if (!run_r) cnt_r <= per_r;
      end else if (pend_r && tick) begin
        pend_r <= 1'b0;
        run_r  <= 1'b1;                                           // RL10
      end else if (hit_zero) begin
        if (auto_r) cnt_r <= per_r;                               // RL12
        else begin
          cnt_r <= 4'h0;                                          // RL13
          run_r <= 1'b0;
        end
      end else if (run_r && tick) cnt_r <= cnt_r - 4'h1;
    end
  end

  // Interrupt flag: a new zero wins over a software clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) irqf_r <= 1'b0;
    else if (hit_zero) irqf_r <= 1'b1;                            // RL8 RL7
    else if (w_irq && wdata[0]) irqf_r <= 1'b0;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_r <= TGT_DIV_RST;
      sq_r  <= 1'b0;
    end else if (!tone_active || half == 5'h00) begin             // RL4 RL6
      div_r <= TGT_DIV_RST;
      sq_r  <= 1'b0;
    end else if (div_end) begin                                   // RL1
      div_r <= TGT_DIV_RST;
      sq_r  <= !sq_r;
    end else div_r <= div_r + 5'h01;
  end

  wire [3:0] rd_mux = (addr == TGT_ADDR_SEL)  ? sel_r :
                      (addr == TGT_ADDR_TIM)  ? {tone_active, auto_r, tsh_r, tsl_r} :
                      (addr == TGT_ADDR_IRQ)  ? {3'h0, irqf_r} :
                      (addr == TGT_ADDR_MASK) ? {3'h0, mask_r} : 4'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_r        <= 4'h0;
      tone_out       <= 1'b0;
      tone_oe        <= 1'b0;
      tone_timer_irq <= 1'b0;
    end else begin
      rdata_r        <= rd ? rd_mux : 4'h0;
      tone_out       <= sq_r;
      tone_oe        <= !sel_r[TGT_BIT_FLOAT];                    // RL5
      tone_timer_irq <= irqf_r && mask_r;
    end
  end
  assign rdata = rdata_r;

  silence_off_a: assert property (@(posedge mclk) disable iff (rst)
    !tone_active |=> ##1 !tone_out) else $error("tone not low when idle"); // RL4
  float_a: assert property (@(posedge mclk) disable iff (rst)
    w_sel && wdata[3] |=> ##1 !tone_oe) else $error("pin not floated");    // RL5
  zero_stop_a: assert property (@(posedge mclk) disable iff (rst)
    per_zero_wr |=> !run_r && !auto_r && !hit_zero) else $error("zero write"); // RL14
  irq_set_a: assert property (@(posedge mclk) disable iff (rst)
    hit_zero |=> irqf_r) else $error("irq flag missed");          // RL8
  reload_a: assert property (@(posedge mclk) disable iff (rst)
    hit_zero && auto_r && !w_per |=> run_r && cnt_r == $past(per_r)) else $error("no reload"); // RL12
  single_stop_a: assert property (@(posedge mclk) disable iff (rst)
    hit_zero && !auto_r && !w_per && !auto_set |=> !run_r) else $error("no stop"); // RL10
  tick_start_a: assert property (@(posedge mclk) disable iff (rst)
    pend_r && !tick && !w_per && !auto_set && !per_zero_wr |=> !run_r) else $error("early start"); // RL11
  auto_go_a: assert property (@(posedge mclk) disable iff (rst)
    auto_set && per_r != 0 && !w_per |=> run_r) else $error("auto not immediate"); // RL15
  force_on_a: assert property (@(posedge mclk) disable iff (rst)
    w_tim && wdata[3] |=> tone_active) else $error("force ignored"); // RL3
  cv_single_c: cover property (@(posedge mclk) disable iff (rst) hit_zero && !auto_r);
  cv_auto_c: cover property (@(posedge mclk) disable iff (rst) hit_zero && auto_r);
  cv_tone_c: cover property (@(posedge mclk) disable iff (rst) tone_out ##1 !tone_out);
endmodule
`default_nettype wire

// ---- test/test_tone_generator_with_timer.sv ----
// Self-checking bench for the tone generator with duration timer
`timescale 1ns/100ps
`default_nettype none
module test_tone_generator_with_timer import tgt_pkg::*;;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [3:0]  wdata = 4'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [3:0]  rdata;
  logic [15:0] presc_ck = 16'h0000;
  logic        tone_out;
  logic        tone_oe;
  logic        tone_timer_irq;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n;
  int          half[7] = '{4, 5, 6, 7, 8, 10, 12};

  tgt_top uut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .presc_ck(presc_ck), .tone_out(tone_out), .tone_oe(tone_oe),
    .tone_timer_irq(tone_timer_irq));

  always #5 mclk = ~mclk;

  // Free-running prescaler: tap 3 has a period of 16 clocks
  always @(posedge mclk) begin
    presc_ck <= presc_ck + 16'h0001;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [3:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string nm, input logic [2:0] a, input logic [3:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 chk(nm, e, rdata);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Cycles until the tone changes level, bounded
  task automatic phase(output int k);
    logic v;
    v = tone_out;
    k = 0;
    while (tone_out === v && k < 40) begin
      step(1);
      k++;
    end
  endtask

  task automatic wait_irq(output int k);
    k = 0;
    while (tone_timer_irq !== 1'b1 && k < 300) begin
      step(1);
      k++;
    end
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    // Pin floats while reset holds; the float bit then reads back as zero
    #1 chk("oe", 4'h0, {3'h0, tone_oe});
    rd_chk("sel", TGT_ADDR_SEL, 4'h0);
    rd_chk("tim", TGT_ADDR_TIM, 4'h0);
    wr_reg(TGT_ADDR_TIM, 4'h8);
    rd_chk("active", TGT_ADDR_TIM, 4'h8);
    for (int s = 1; s < 8; s++) begin
      wr_reg(TGT_ADDR_SEL, s[3:0]);
      phase(n);
      for (int i = 0; i < 2; i++) begin
        phase(n);
        chk("half", half[s-1][3:0], n[3:0]);
      end
    end
    chk("oe", 4'h1, {3'h0, tone_oe});
    wr_reg(TGT_ADDR_SEL, 4'h9);
    step(2);
    chk("float", 4'h0, {3'h0, tone_oe});
    wr_reg(TGT_ADDR_SEL, 4'h1);
    wr_reg(TGT_ADDR_TIM, 4'h0);
    step(4);
    chk("idle", 4'h0, {3'h0, tone_out});
    // Single shot with silence selected
    wr_reg(TGT_ADDR_SEL, 4'h0);
    wr_reg(TGT_ADDR_MASK, 4'h1);
    wr_reg(TGT_ADDR_PER, 4'h3);
    step(24);
    rd_chk("run", TGT_ADDR_TIM, 4'h8);
    chk("silent", 4'h0, {3'h0, tone_out});
    wait_irq(n);
    chk("len", 4'h1, {3'h0, n >= 20 && n <= 48});
    rd_chk("stop", TGT_ADDR_TIM, 4'h0);
    wr_reg(TGT_ADDR_IRQ, 4'h1);
    step(2);
    chk("clr", 4'h0, {3'h0, tone_timer_irq});
    wr_reg(TGT_ADDR_PER, 4'h5);
    step(30);
    wr_reg(TGT_ADDR_PER, 4'h0);
    step(120);
    chk("zstop", 4'h0, {3'h0, tone_timer_irq});
    rd_chk("zidle", TGT_ADDR_TIM, 4'h0);
    // Auto reload, programmed in the documented order
    wr_reg(TGT_ADDR_PER, 4'h2);
    wr_reg(TGT_ADDR_TIM, 4'h4);
    rd_chk("auto", TGT_ADDR_TIM, 4'hC);
    wait_irq(n);
    chk("z1", 4'h1, {3'h0, n <= 40});
    wr_reg(TGT_ADDR_IRQ, 4'h1);
    // The pin lags the cleared flag by one cycle
    step(2);
    wait_irq(n);
    chk("z2", 4'h1, {3'h0, n >= 26 && n <= 36});
    wr_reg(TGT_ADDR_PER, 4'h0);
    rd_chk("aoff", TGT_ADDR_TIM, 4'h0);
    // Slower tap: one tick of 64 clocks after the start tick
    wr_reg(TGT_ADDR_IRQ, 4'h1);
    wr_reg(TGT_ADDR_TIM, 4'h1);
    wr_reg(TGT_ADDR_PER, 4'h1);
    step(2);
    chk("clr2", 4'h0, {3'h0, tone_timer_irq});
    wait_irq(n);
    chk("tap", 4'h1, {3'h0, n >= 60 && n <= 140});
    end_sim();
  end
endmodule
`default_nettype wire
